// *** core/fpu_trap_consts.svh ***
/*
 * constants of the floating point availability trap: register byte
 * offsets, control bit positions, reset values and exception vectors.
 * assumes inclusion by bare name from the package; the design files use its macros without including it.
 */
`ifndef FPU_TRAP_CONSTS_SVH
`define FPU_TRAP_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FT_ADDR_W 8
`define FT_OFS_CTRL 8'h00
`define FT_OFS_FSW 8'h04
`define FT_OFS_IRQ_STAT 8'h08
`define FT_OFS_IRQ_MASK 8'h0C
`define FT_OFS_FAULT 8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FT_BIT_EM 2
`define FT_BIT_TS 3
`define FT_BIT_NE 5
`define FT_FLAGS_W 6
`define FT_FSW_PEND 7
`define FT_IRQ_W 4
`define FT_IRQ_DNA 0
`define FT_IRQ_NUM 1
`define FT_IRQ_UD 2
`define FT_IRQ_ERR 3
`define FT_FAULT_TAG_LSB 16

// ----------------------------------------------------------------
// vectors, responses, reset values
// ----------------------------------------------------------------
`define FT_VEC_UD 8'h06
`define FT_VEC_DNA 8'h07
`define FT_VEC_NUM 8'h10
`define FT_RESP_OKAY 2'h0
`define FT_RESP_SLVERR 2'h2
`define FT_ERR_DELAY 2
`define FT_RST_CTRL 1'h0

`endif

// *** core/fpu_trap_pkg.sv ***
/*
 * types shared by the trap logic: instruction classes and the error
 * output sequencer states.
 * assumes nothing beyond the constants header.
 */
package fpu_trap_pkg;
    `include "fpu_trap_consts.svh"

    // class of the instruction the core is about to start
    typedef enum logic [2:0] {
        INSN_FP_WAIT,
        INSN_FP_NOWAIT,
        INSN_NOWAIT_SAVE,
        INSN_NOWAIT_CLEAR,
        INSN_RESTORE,
        INSN_SIMD_INT,
        INSN_CLEAR_TASK_SWITCHED_INSN,
        INSN_OTHER
    } insn_class_e;

    typedef enum logic [1:0] {ERR_IDLE, ERR_WAIT, ERR_ON, ERR_KICK} err_state_e;
endpackage

// *** core/fpu_insn_decide.sv ***
/*
 * combinational fault decision for one offered instruction.
 * assumes the caller registers the result and applies the state effects.
 */
`timescale 1ns/100ps
module fpu_insn_decide import fpu_trap_pkg::*; (
    // offered instruction
    input wire insn_class_e insn_class,
    // control state
    input wire logic task_switched_flag,
    input wire logic emulation_flag,
    input wire logic native_error_mode,
    input wire logic pending,
    // decision
    output logic fault,
    output logic [7:0] vector,
    output logic executes
);
    logic is_fp;

    // ----------------------------------------------------------------
    // priority: invalid opcode, then availability, then numeric trap
    // ----------------------------------------------------------------
    always_comb begin
        is_fp = (insn_class == INSN_FP_WAIT) || (insn_class == INSN_FP_NOWAIT) ||
                (insn_class == INSN_NOWAIT_SAVE) || (insn_class == INSN_NOWAIT_CLEAR) ||
                (insn_class == INSN_RESTORE);
        fault = 1'b0;
        vector = 8'h00;
        if (insn_class == INSN_SIMD_INT && emulation_flag) begin
            fault = 1'b1;
            vector = `FT_VEC_UD;
        end else if (is_fp && (task_switched_flag || emulation_flag)) begin
            // one fault however many flags are set; numeric waits behind it
            fault = 1'b1;
            vector = `FT_VEC_DNA;
        end else if (native_error_mode && pending &&
                     (insn_class == INSN_FP_WAIT || insn_class == INSN_RESTORE)) begin
            // no-wait classes never take this path
            fault = 1'b1;
            vector = `FT_VEC_NUM;
        end
        executes = !fault;
    end
endmodule

// *** core/fpu_error_signal.sv ***
/*
 * drives the floating point error output from the pending numeric state.
 * assumes pending and kick come from registers in the same clock domain.
 */
`timescale 1ns/100ps
module fpu_error_signal import fpu_trap_pkg::*; #(
    parameter int DELAY = `FT_ERR_DELAY
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // cause
    input wire logic pending,
    input wire logic kick,
    // result
    output logic err_out
);
    localparam int CNT_W = $clog2(DELAY + 1);

    initial begin
        if (DELAY < 1 || DELAY > 255) $error("fpu_error_signal: DELAY out of range");
    end

    err_state_e state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;

    // ----------------------------------------------------------------
    // sequencer: a system delay before raising, a held pulse on kick
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            ERR_IDLE: if (pending) begin
                state_next = ERR_WAIT;
                cnt_next = CNT_W'(DELAY - 1);
            end
            ERR_WAIT: if (!pending) begin
                state_next = ERR_IDLE;
            end else if (cnt_reg == '0) begin
                state_next = ERR_ON;
            end else begin
                cnt_next = cnt_reg - 1'b1;
            end
            ERR_ON: if (!pending) begin
                state_next = ERR_IDLE;
            end
            ERR_KICK: if (cnt_reg == '0) begin
                state_next = pending ? ERR_ON : ERR_IDLE;
            end else begin
                cnt_next = cnt_reg - 1'b1;
            end
        endcase
        // a no-wait save over a pending exception pulses the output
        if (kick) begin
            state_next = ERR_KICK;
            cnt_next = CNT_W'(DELAY - 1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ERR_IDLE;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    assign err_out = (state_reg == ERR_ON) || (state_reg == ERR_KICK);
endmodule

// *** core/fpu_availability_trap.sv ***
/*
 * floating point availability trap unit with an AXI4-Lite register slave.
 * assumes the core offers one instruction per insn_valid pulse, waits for
 * insn_done, and re-issues a faulted instruction only through the replay.
 */
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module fpu_availability_trap import fpu_trap_pkg::*; #(
    parameter int TAG_W = 16,
    parameter int ERR_DELAY = `FT_ERR_DELAY
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [`FT_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [`FT_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // core instruction stream
    input wire logic task_switch,
    input wire logic insn_valid,
    input wire insn_class_e insn_class,
    input wire logic [TAG_W-1:0] insn_tag,
    input wire logic handler_return,
    // floating point datapath
    input wire logic numeric_exc,
    input wire logic [`FT_FLAGS_W-1:0] numeric_flags,
    input wire logic numeric_unmasked,
    input wire logic [`FT_FLAGS_W-1:0] restore_flags,
    input wire logic restore_unmasked,
    // results
    output logic insn_done,
    output logic insn_fault,
    output logic [7:0] fault_vector,
    output logic [TAG_W-1:0] fault_tag,
    output logic replay_valid,
    output logic [TAG_W-1:0] replay_tag,
    output logic fpu_error_output,
    output logic irq
);
    initial begin
        if (TAG_W < 1 || TAG_W > 16) $error("fpu_availability_trap: TAG_W out of range");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
    logic [`FT_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic ts_reg, ts_next, em_reg, em_next, ne_reg, ne_next;
    logic [`FT_FLAGS_W-1:0] flags_reg, flags_next;
    logic pend_reg, pend_next;
    logic done_reg, done_next, fault_reg, fault_next;
    logic [7:0] vec_reg, vec_next;
    logic [TAG_W-1:0] ftag_reg, ftag_next, rtag_reg, rtag_next;
    logic owe_reg, owe_next, replay_reg, replay_next;
    logic [`FT_IRQ_W-1:0] istat_reg, istat_next, imask_reg, imask_next;
    logic err_q_reg, kick_reg, kick_next;
    logic dec_fault, dec_exec, wr_fire, wr_low, err_out;
    logic [7:0] dec_vec;
    logic [`FT_IRQ_W-1:0] ev;

    fpu_insn_decide u_decide (
        .insn_class(insn_class),
        .task_switched_flag(ts_reg),
        .emulation_flag(em_reg),
        .native_error_mode(ne_reg),
        .pending(pend_reg),
        .fault(dec_fault),
        .vector(dec_vec),
        .executes(dec_exec)
    );

    fpu_error_signal #(.DELAY(ERR_DELAY)) u_err (
        .aclk(aclk),
        .aresetn(aresetn),
        .pending(pend_reg),
        .kick(kick_reg),
        .err_out(err_out)
    );

    // ----------------------------------------------------------------
    // axi write channels: address and data taken in either order
    // ----------------------------------------------------------------
    assign awready = !aw_hold_reg && !bvalid_reg;
    assign wready = !w_hold_reg && !bvalid_reg;
    assign wr_fire = aw_hold_reg && w_hold_reg;
    assign wr_low = wr_fire && w_strb_reg[0]; // control fields live in byte 0

    always_comb begin
        aw_hold_next = aw_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_hold_next = w_hold_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (awvalid && awready) begin
            aw_hold_next = 1'b1;
            aw_addr_next = awaddr;
        end
        if (wvalid && wready) begin
            w_hold_next = 1'b1;
            w_data_next = wdata;
            w_strb_next = wstrb;
        end
        if (bvalid_reg && bready) bvalid_next = 1'b0;
        if (wr_fire) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            unique case (aw_addr_reg)
                `FT_OFS_CTRL, `FT_OFS_FSW, `FT_OFS_IRQ_STAT, `FT_OFS_IRQ_MASK,
                `FT_OFS_FAULT: bresp_next = `FT_RESP_OKAY;
                default: bresp_next = `FT_RESP_SLVERR;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // axi read channel: one read under way, answered a cycle after address
    // ----------------------------------------------------------------
    assign arready = !rvalid_reg;

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && rready) rvalid_next = 1'b0;
        if (arvalid && arready) begin
            rvalid_next = 1'b1;
            rdata_next = 32'h0000_0000;
            rresp_next = `FT_RESP_OKAY;
            unique case (araddr)
                `FT_OFS_CTRL: begin
                    rdata_next[`FT_BIT_EM] = em_reg;
                    rdata_next[`FT_BIT_TS] = ts_reg;
                    rdata_next[`FT_BIT_NE] = ne_reg;
                end
                `FT_OFS_FSW: begin
                    rdata_next[`FT_FLAGS_W-1:0] = flags_reg;
                    rdata_next[`FT_FSW_PEND] = pend_reg;
                end
                `FT_OFS_IRQ_STAT: rdata_next[`FT_IRQ_W-1:0] = istat_reg;
                `FT_OFS_IRQ_MASK: rdata_next[`FT_IRQ_W-1:0] = imask_reg;
                `FT_OFS_FAULT: begin
                    rdata_next[7:0] = vec_reg;
                    rdata_next[`FT_FAULT_TAG_LSB +: TAG_W] = ftag_reg;
                end
                default: rresp_next = `FT_RESP_SLVERR;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // control register: set by hardware wins over any clear
    // ----------------------------------------------------------------
    always_comb begin
        ts_next = ts_reg;
        em_next = em_reg;
        ne_next = ne_reg;
        if (wr_low && aw_addr_reg == `FT_OFS_CTRL) begin
            ts_next = w_data_reg[`FT_BIT_TS];
            em_next = w_data_reg[`FT_BIT_EM];
            ne_next = w_data_reg[`FT_BIT_NE];
        end
        if (insn_valid && insn_class == INSN_CLEAR_TASK_SWITCHED_INSN) ts_next = 1'b0;
        if (task_switch) ts_next = 1'b1;
    end

    // ----------------------------------------------------------------
    // instruction outcome and numeric exception state
    // ----------------------------------------------------------------
    always_comb begin
        flags_next = flags_reg;
        pend_next = pend_reg;
        done_next = insn_valid;
        fault_next = insn_valid && dec_fault;
        vec_next = vec_reg;
        ftag_next = ftag_reg;
        kick_next = 1'b0;
        if (insn_valid && dec_fault) begin
            vec_next = dec_vec;
            ftag_next = insn_tag;
        end
        // faulted state is untouched, so only executing classes act here
        if (insn_valid && dec_exec) begin
            unique case (insn_class)
                INSN_RESTORE: begin
                    flags_next = restore_flags;
                    pend_next = restore_unmasked;
                end
                INSN_NOWAIT_SAVE: begin
                    kick_next = pend_reg;
                    flags_next = '0;
                    pend_next = 1'b0;
                end
                INSN_NOWAIT_CLEAR: begin
                    flags_next = '0;
                    pend_next = 1'b0;
                end
                default: ;
            endcase
        end
        // a new exception in the clearing cycle is kept
        if (numeric_exc) begin
            flags_next = flags_next | numeric_flags;
            pend_next = pend_next | numeric_unmasked;
        end
    end

    // ----------------------------------------------------------------
    // replay of the instruction that took the availability fault
    // ----------------------------------------------------------------
    always_comb begin
        owe_next = owe_reg;
        rtag_next = rtag_reg;
        replay_next = 1'b0;
        if (handler_return && owe_reg) begin
            replay_next = 1'b1;
            owe_next = 1'b0;
        end
        if (insn_valid && dec_fault && dec_vec == `FT_VEC_DNA) begin
            owe_next = 1'b1;
            rtag_next = insn_tag;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status and mask, write one to clear, events win
    // ----------------------------------------------------------------
    always_comb begin
        ev = '0;
        ev[`FT_IRQ_DNA] = fault_reg && vec_reg == `FT_VEC_DNA;
        ev[`FT_IRQ_NUM] = fault_reg && vec_reg == `FT_VEC_NUM;
        ev[`FT_IRQ_UD] = fault_reg && vec_reg == `FT_VEC_UD;
        ev[`FT_IRQ_ERR] = err_out && !err_q_reg;
        istat_next = istat_reg;
        imask_next = imask_reg;
        if (wr_low && aw_addr_reg == `FT_OFS_IRQ_STAT) begin
            istat_next = istat_reg & ~w_data_reg[`FT_IRQ_W-1:0];
        end
        if (wr_low && aw_addr_reg == `FT_OFS_IRQ_MASK) imask_next = w_data_reg[`FT_IRQ_W-1:0];
        istat_next = istat_next | ev;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_hold_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `FT_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= `FT_RESP_OKAY;
            ts_reg <= `FT_RST_CTRL;
            em_reg <= `FT_RST_CTRL;
            ne_reg <= `FT_RST_CTRL;
            flags_reg <= '0;
            pend_reg <= 1'b0;
            done_reg <= 1'b0;
            fault_reg <= 1'b0;
            vec_reg <= 8'h00;
            ftag_reg <= '0;
            rtag_reg <= '0;
            owe_reg <= 1'b0;
            replay_reg <= 1'b0;
            istat_reg <= '0;
            imask_reg <= '0;
            err_q_reg <= 1'b0;
            kick_reg <= 1'b0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            aw_addr_reg <= aw_addr_next;
            w_hold_reg <= w_hold_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            ts_reg <= ts_next;
            em_reg <= em_next;
            ne_reg <= ne_next;
            flags_reg <= flags_next;
            pend_reg <= pend_next;
            done_reg <= done_next;
            fault_reg <= fault_next;
            vec_reg <= vec_next;
            ftag_reg <= ftag_next;
            rtag_reg <= rtag_next;
            owe_reg <= owe_next;
            replay_reg <= replay_next;
            istat_reg <= istat_next;
            imask_reg <= imask_next;
            err_q_reg <= err_out;
            kick_reg <= kick_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign insn_done = done_reg;
    assign insn_fault = fault_reg;
    assign fault_vector = vec_reg;
    assign fault_tag = ftag_reg;
    assign replay_valid = replay_reg;
    assign replay_tag = rtag_reg;
    assign fpu_error_output = err_out;
    assign irq = |(istat_reg & imask_reg);
endmodule

// *** tb/fpu_trap_asserts.sv ***
/* port checker of the availability trap unit, bound into its top module.
   assumes one clock domain and the synchronous active-low reset. */
`timescale 1ns/100ps
module fpu_trap_asserts import fpu_trap_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic bvalid,
    input wire logic bready,
    // instruction side
    input wire logic task_switch,
    input wire logic insn_valid,
    input wire insn_class_e insn_class,
    input wire logic handler_return,
    input wire logic insn_done,
    input wire logic insn_fault,
    input wire logic [7:0] fault_vector,
    input wire logic replay_valid
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // start decodes; no-wait classes are the ones that must never trap on 16
    wire fp_go = insn_valid && insn_class == INSN_FP_WAIT;
    wire nw_go = insn_valid && insn_class inside {INSN_FP_NOWAIT, INSN_NOWAIT_SAVE,
        INSN_NOWAIT_CLEAR};
    a_done_follows: assert property (insn_valid |=> insn_done)
        else $error("instruction not answered");
    a_switch_faults: assert property ($past(task_switch) && fp_go
        |=> insn_fault && fault_vector == 8'h07) else $error("no fault after switch");
    a_fault_once: assert property (insn_fault |-> insn_done && $past(insn_valid))
        else $error("stray fault pulse");
    a_nowait_no16: assert property (nw_go |=> !(insn_fault && fault_vector == 8'h10))
        else $error("no-wait took numeric trap");
    a_simd_no_dna: assert property (insn_valid && insn_class == INSN_SIMD_INT
        |=> !(insn_fault && fault_vector == 8'h07)) else $error("simd gave vector 7");
    a_replay_cause: assert property (replay_valid |-> $past(handler_return))
        else $error("replay without return");
    a_bresp_hold: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read not answered");
    c_fault: cover property (fp_go ##1 insn_fault);
    c_replay: cover property (replay_valid);
    c_nowait: cover property (nw_go);
endmodule
bind fpu_availability_trap fpu_trap_asserts chk_i (.*);

// *** tb/kernel_model.sv ***
/* kernel side of the trap: returns from the availability handler a fixed
   time after each availability fault.
   assumes the bench issues the handler's own instructions meanwhile. */
`timescale 1ns/100ps
module kernel_model #(
    parameter int LATENCY = 6
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // fault report
    input wire logic insn_fault,
    input wire logic [7:0] fault_vector,
    // handler exit
    output logic handler_return
);
    int cnt;
    // a new fault restarts the handler, as a nested entry would
    always @(posedge aclk) begin
        handler_return <= 1'h0;
        if (!aresetn)
            cnt <= 0;
        else if (insn_fault && fault_vector == 8'h07)
            cnt <= LATENCY;
        else if (cnt > 0) begin
            cnt <= cnt - 1;
            handler_return <= (cnt == 1);
        end
    end
endmodule

// *** tb/test_fpu_availability_trap.sv ***
/* self-checking bench of the trap unit: bus tasks and instruction tasks.
   assumes the kernel model answers each availability fault. */
`timescale 1ns/100ps
module test_fpu_availability_trap import fpu_trap_pkg::*;;
    logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, task_switch = 1'h0, insn_valid = 1'h0;
    logic numeric_exc = 1'h0, numeric_unmasked = 1'h0, restore_unmasked = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, fault_vector;
    logic [31:0] wdata = 32'h0, rd, rdata;
    logic [3:0] wstrb = 4'hF;
    logic [5:0] numeric_flags = 6'h00, restore_flags = 6'h00;
    insn_class_e insn_class = INSN_OTHER;
    logic [15:0] insn_tag = 16'h0, fault_tag, replay_tag;
    logic awready, wready, bvalid, arready, rvalid, insn_done, insn_fault, irq;
    logic replay_valid, fpu_error_output, handler_return, ta, tw, tr, dn;
    logic [1:0] bresp, rresp, rs;
    int miscompares = 0, tests_run = 0, cyc = 0;
    fpu_availability_trap dut (.*);
    kernel_model #(.LATENCY(6)) kern (.*);
    initial forever #10 aclk = ~aclk;
    // a hang is cut short well past the hundred or so cycles the run needs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            finish_test;
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // readies are read at the falling edge, where they have settled; response
    // readies stay high between transfers so no strobe drops and rises in one step
    task wr(input logic [7:0] a, input logic [31:0] d);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        dn = 1'h0;
        while (!dn) begin
            @(negedge aclk);
            {ta, tw, tr, rs} = {awvalid && awready, wvalid && wready, bvalid, bresp};
            @(posedge aclk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            dn = tr;
        end
    endtask
    task rd_t(input logic [7:0] a);
        {araddr, arvalid, rready} <= {a, 2'h3};
        dn = 1'h0;
        while (!dn) begin
            @(negedge aclk);
            {ta, tr, rd, rs} = {arvalid && arready, rvalid, rdata, rresp};
            @(posedge aclk);
            if (ta) arvalid <= 1'h0;
            dn = tr;
        end
    endtask
    // e is {fault, vector}; the vector only counts when a fault is flagged
    task ins(input insn_class_e c, input logic [8:0] e);
        insn_class <= c;
        insn_tag <= insn_tag + 16'h1;
        insn_valid <= 1'h1;
        @(posedge aclk);
        insn_valid <= 1'h0;
        @(negedge aclk);
        chk({23'h0, insn_fault, insn_fault ? fault_vector : 8'h00}, {23'h0, e});
        @(posedge aclk);
    endtask
    task po(input logic [1:0] e);
        @(negedge aclk);
        chk({30'h0, fpu_error_output, irq}, {30'h0, e});
        @(posedge aclk);
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd_t(8'h00);
        chk(rd, 32'h0);
        rd_t(8'h40);
        chk({30'h0, rs}, 32'h2);
        wr(8'h0C, 32'h1);
        ins(INSN_FP_WAIT, 9'h000);
        wr(8'h00, 32'h8);
        chk({30'h0, rs}, 32'h0);
        ins(INSN_FP_WAIT, 9'h107);
        po(2'h1);
        do @(negedge aclk); while (!replay_valid);
        chk({16'h0, replay_tag}, {16'h0, insn_tag});
        @(posedge aclk);
        rd_t(8'h00);
        chk(rd, 32'h8);
        wr(8'h08, 32'h1);
        po(2'h0);
        wr(8'h0C, 32'h0);
        ins(INSN_CLEAR_TASK_SWITCHED_INSN, 9'h000);
        ins(INSN_FP_WAIT, 9'h000);
        ins(INSN_SIMD_INT, 9'h000);
        ins(INSN_OTHER, 9'h000);
        task_switch <= 1'h1;
        @(posedge aclk);
        task_switch <= 1'h0;
        ins(INSN_FP_WAIT, 9'h107);
        wr(8'h00, 32'h4);
        ins(INSN_FP_NOWAIT, 9'h107);
        ins(INSN_SIMD_INT, 9'h106);
        wr(8'h00, 32'hC);
        ins(INSN_RESTORE, 9'h107);
        {numeric_exc, numeric_flags, numeric_unmasked} <= {1'h1, 6'h01, 1'h1};
        @(posedge aclk);
        numeric_exc <= 1'h0;
        rd_t(8'h04);
        chk(rd, 32'h81);
        wr(8'h00, 32'h28);
        ins(INSN_FP_WAIT, 9'h107);
        wr(8'h00, 32'h20);
        ins(INSN_FP_NOWAIT, 9'h000);
        ins(INSN_FP_WAIT, 9'h110);
        chk({16'h0, fault_tag}, {16'h0, insn_tag});
        rd_t(8'h10);
        chk(rd, {insn_tag, 16'h0010});
        rd_t(8'h08);
        chk(rd, 32'h0000000F);
        wr(8'h00, 32'h0);
        ins(INSN_FP_WAIT, 9'h000);
        po(2'h2);
        ins(INSN_NOWAIT_SAVE, 9'h000);
        po(2'h2);
        po(2'h2);
        po(2'h0);
        {restore_flags, restore_unmasked} <= {6'h04, 1'h1};
        ins(INSN_RESTORE, 9'h000);
        rd_t(8'h04);
        chk(rd, 32'h84);
        wr(8'h00, 32'h20);
        ins(INSN_FP_WAIT, 9'h110);
        ins(INSN_NOWAIT_CLEAR, 9'h000);
        finish_test;
    end
endmodule
